// ### logic/rxc_pkg.sv
// Constants, field layout and carrier types of the receiver configuration bank.
// Assumes a single 100 MHz clock and a synchronous active-high pin_reset_state.
`default_nettype none
package rxc_pkg;
  // ----------------------------------------------------------------
  // Register port geometry and internal addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 36;
  localparam logic [9:0] ADDR_MODE = 10'h300;
  localparam logic [9:0] ADDR_TUNE = 10'h303;
  localparam logic [9:0] ADDR_PHASE = 10'h304;
  localparam logic [9:0] ADDR_IN_SCALE = 10'h305;
  localparam logic [9:0] ADDR_R1 = 10'h306;
  localparam logic [9:0] ADDR_S2 = 10'h307;
  localparam logic [9:0] ADDR_R2 = 10'h308;
  localparam logic [9:0] ADDR_OUT_CTL = 10'h309;
  localparam logic [9:0] ADDR_RF = 10'h30a;
  localparam logic [9:0] ADDR_COEF_OFF = 10'h30b;
  localparam logic [9:0] ADDR_TAPS = 10'h30c;
  localparam logic [9:0] ADDR_RSVD = 10'h30d;
  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam int MODE_SOFT_BIT = 0;
  localparam int MODE_DIV_BIT = 1;
  localparam int MODE_CPLX_BIT = 2;
  localparam int MODE_SYNC_BIT = 3;
  localparam int MODE_USED_MSB = 3;
  localparam int S1_MSB = 2;
  localparam int S1_LSB = 0;
  localparam int EXPONENT_DIRECTION_INVERT_BIT = 4;
  localparam int EXPONENT_GAIN_OFFSET_MSB = 7;
  localparam int EXPONENT_GAIN_OFFSET_LSB = 5;
  localparam int SOUT_MSB = 2;
  localparam int SOUT_LSB = 0;
  localparam logic [2:0] S1_MAX = 3'h6;
  localparam logic [4:0] S2_MAX = 5'h14;
  localparam logic [3:0] SOUT_BASE = 4'h7;
  // ----------------------------------------------------------------
  // Datapath widths and timing
  // ----------------------------------------------------------------
  localparam int FE_W = 40;
  localparam int FIR_W = 23;
  localparam int OUT_W = 32;
  localparam int POL_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int RESET_MIN_NS = 30;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RXC_WL_16 = 2'h0,
    RXC_WL_24 = 2'h1,
    RXC_WL_32 = 2'h2
  } rxc_wl_e;
  typedef enum logic [1:0] {
    RXC_TAP_IDLE = 2'h0,
    RXC_TAP_WALK = 2'h1,
    RXC_TAP_LAST = 2'h3
  } rxc_tap_e;
  typedef struct packed {
    logic [7:0] mode;
    logic [31:0] osc_tuning_word;
    logic [15:0] osc_phase_shift;
    logic [7:0] input_and_first_decim_scale;
    logic [7:0] first_decim_ratio_minus_one;
    logic [4:0] second_decim_scale;
    logic [7:0] second_decim_ratio_minus_one;
    logic [7:0] output_scale_control;
    logic [7:0] fir_decim_ratio_minus_one;
    logic [7:0] fir_coef_base_offset;
    logic [7:0] fir_tap_count_minus_one;
    logic [7:0] reserved_write_zero;
  } rxc_cfg_s;
  typedef struct packed {
    logic valid;
    logic [FIR_W-1:0] data;
  } rxc_fir_s;
endpackage : rxc_pkg
`default_nettype wire

// ### logic/rxc_top.sv
// Receiver configuration bank with front-end scaling, decimator integrators,
// oscillator phase, coefficient walk, output scaling and an output FIFO.
// Assumes a host on the internal register port and a downstream FIR that
// returns its 23-bit result; all inputs are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Output FIFO
// ------------------------------------------------------------------
module rxc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rxc_fifo

// What this block does
// - Holds 32-bit unsigned oscillator tuning word
// - Phase offset register added to oscillator phase
// - First scale bits 2-0, 0..6, shifts down
// - Exponent invert chooses shift direction per exponent
// - Exponent offset bits 7-5 adds input gain
// - First ratio is rate minus one, advise 15
// - Second scale bits 4-0, 0..20, shifts down
// - Second ratio is rate minus one, advise 31
// - 16-bit output: times 2^(7-scale), rounded
// - Output scale ignored for 24/32-bit words
// - FIR ratio is rate minus one, advise 31
// - Coefficients read from offset through offset+taps-1
// - Tap register is taps minus one, no symmetry
// - Pin_reset_state clears integrators and phase accumulator
// - After pin_reset_state: soft reset, idle, slave
// - First output is zero; data memories untouched
// - Mode bits select diversity, complex, sync master
module rxc_top (
  // Clock and pin_reset_state
  input wire logic clk,
  input wire logic rst,
  // Internal register port
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [rxc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [rxc_pkg::DATA_W-1:0] cfg_wdata,
  output logic [rxc_pkg::DATA_W-1:0] cfg_rdata,
  // Configuration and mode view
  output rxc_pkg::rxc_cfg_s cfg,
  output logic soft_reset_active,
  output logic diversity_real_mode,
  output logic single_complex_mode,
  output logic sync_master,
  // Input sample port
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_mantissa,
  input wire logic [2:0] input_exponent,
  // Oscillator phase
  output logic [15:0] osc_phase,
  // Decimator outputs
  output logic first_out_valid,
  output logic [rxc_pkg::FE_W-1:0] first_out_data,
  output logic second_in_valid,
  output logic [rxc_pkg::FE_W-1:0] second_in_data,
  // Coefficient walk
  output logic coef_rd_en,
  output logic [7:0] coef_addr,
  output logic coef_walk_busy,
  // FIR result and word length
  input wire rxc_pkg::rxc_fir_s fir_result_23b,
  input wire rxc_pkg::rxc_wl_e serial_word_length,
  // Output sample stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [rxc_pkg::OUT_W-1:0] scaled_output_word
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  rxc_pkg::rxc_cfg_s cfg_q;
  logic [rxc_pkg::DATA_W-1:0] rdata_q;
  logic [rxc_pkg::DATA_W-1:0] rd_mux;
  wire running = !cfg_q.mode[rxc_pkg::MODE_SOFT_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= '0;
      cfg_q.mode <= rxc_pkg::MODE_RESET;
    end else if (cfg_wr_en) begin
      case (cfg_addr)
        rxc_pkg::ADDR_MODE: cfg_q.mode <= cfg_wdata[7:0];
        rxc_pkg::ADDR_TUNE: cfg_q.osc_tuning_word <= cfg_wdata[31:0];
        rxc_pkg::ADDR_PHASE: cfg_q.osc_phase_shift <= cfg_wdata[15:0];
        rxc_pkg::ADDR_IN_SCALE: cfg_q.input_and_first_decim_scale <= cfg_wdata[7:0];
        rxc_pkg::ADDR_R1: cfg_q.first_decim_ratio_minus_one <= cfg_wdata[7:0];
        rxc_pkg::ADDR_S2: cfg_q.second_decim_scale <= cfg_wdata[4:0];
        rxc_pkg::ADDR_R2: cfg_q.second_decim_ratio_minus_one <= cfg_wdata[7:0];
        rxc_pkg::ADDR_OUT_CTL: cfg_q.output_scale_control <= cfg_wdata[7:0];
        rxc_pkg::ADDR_RF: cfg_q.fir_decim_ratio_minus_one <= cfg_wdata[7:0];
        rxc_pkg::ADDR_COEF_OFF: cfg_q.fir_coef_base_offset <= cfg_wdata[7:0];
        rxc_pkg::ADDR_TAPS: cfg_q.fir_tap_count_minus_one <= cfg_wdata[7:0];
        rxc_pkg::ADDR_RSVD: cfg_q.reserved_write_zero <= cfg_wdata[7:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (cfg_addr)
      rxc_pkg::ADDR_MODE: rd_mux[7:0] = cfg_q.mode;
      rxc_pkg::ADDR_TUNE: rd_mux[31:0] = cfg_q.osc_tuning_word;
      rxc_pkg::ADDR_PHASE: rd_mux[15:0] = cfg_q.osc_phase_shift;
      rxc_pkg::ADDR_IN_SCALE: rd_mux[7:0] = cfg_q.input_and_first_decim_scale;
      rxc_pkg::ADDR_R1: rd_mux[7:0] = cfg_q.first_decim_ratio_minus_one;
      rxc_pkg::ADDR_S2: rd_mux[4:0] = cfg_q.second_decim_scale;
      rxc_pkg::ADDR_R2: rd_mux[7:0] = cfg_q.second_decim_ratio_minus_one;
      rxc_pkg::ADDR_OUT_CTL: rd_mux[7:0] = cfg_q.output_scale_control;
      rxc_pkg::ADDR_RF: rd_mux[7:0] = cfg_q.fir_decim_ratio_minus_one;
      rxc_pkg::ADDR_COEF_OFF: rd_mux[7:0] = cfg_q.fir_coef_base_offset;
      rxc_pkg::ADDR_TAPS: rd_mux[7:0] = cfg_q.fir_tap_count_minus_one;
      rxc_pkg::ADDR_RSVD: rd_mux[7:0] = cfg_q.reserved_write_zero;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (cfg_rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg = cfg_q;
  assign soft_reset_active = !running;
  assign diversity_real_mode = cfg_q.mode[rxc_pkg::MODE_DIV_BIT];
  assign single_complex_mode = cfg_q.mode[rxc_pkg::MODE_CPLX_BIT];
  assign sync_master = cfg_q.mode[rxc_pkg::MODE_SYNC_BIT];

  // ----------------------------------------------------------------
  // Oscillator phase accumulator
  // ----------------------------------------------------------------
  logic [31:0] phase_acc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_acc_q <= '0;
    end else if (running) begin
      phase_acc_q <= phase_acc_q + cfg_q.osc_tuning_word;
    end
  end

  assign osc_phase = phase_acc_q[31:16] + cfg_q.osc_phase_shift;

  // ----------------------------------------------------------------
  // Input exponent handling and first scale
  // ----------------------------------------------------------------
  wire exp_inv = cfg_q.input_and_first_decim_scale[rxc_pkg::EXPONENT_DIRECTION_INVERT_BIT];
  wire [2:0] exp_off =
    cfg_q.input_and_first_decim_scale[rxc_pkg::EXPONENT_GAIN_OFFSET_MSB:rxc_pkg::EXPONENT_GAIN_OFFSET_LSB];
  wire [2:0] s1_raw = cfg_q.input_and_first_decim_scale[rxc_pkg::S1_MSB:rxc_pkg::S1_LSB];
  wire [2:0] s1_eff = (s1_raw > rxc_pkg::S1_MAX) ? rxc_pkg::S1_MAX : s1_raw;
  wire [2:0] down_amt = exp_inv ? 3'h0 : input_exponent;
  wire [3:0] up_amt = {1'b0, exp_off} + (exp_inv ? {1'b0, input_exponent} : 4'h0);
  wire signed [rxc_pkg::FE_W-1:0] fe_ext = rxc_pkg::FE_W'(signed'(in_mantissa));
  wire signed [rxc_pkg::FE_W-1:0] fe_gain = (fe_ext <<< up_amt) >>> down_amt;
  wire signed [rxc_pkg::FE_W-1:0] fe_scaled = fe_gain >>> s1_eff;
  logic fifo_in_ready;
  wire take_in = in_valid && in_ready;
  assign in_ready = running && fifo_in_ready;

  // ----------------------------------------------------------------
  // First decimator: two integrators, decimation, two combs
  // ----------------------------------------------------------------
  logic signed [rxc_pkg::FE_W-1:0] int1_q;
  logic signed [rxc_pkg::FE_W-1:0] int2_q;
  logic signed [rxc_pkg::FE_W-1:0] comb1_q;
  logic signed [rxc_pkg::FE_W-1:0] comb2_q;
  logic signed [rxc_pkg::FE_W-1:0] first_q;
  logic [7:0] cnt1_q;
  logic first_v_q;
  wire cnt1_wrap = (cnt1_q >= cfg_q.first_decim_ratio_minus_one);
  wire signed [rxc_pkg::FE_W-1:0] c1 = int2_q - comb1_q;
  wire signed [rxc_pkg::FE_W-1:0] c2 = c1 - comb2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      int1_q <= '0;
      int2_q <= '0;
      comb1_q <= '0;
      comb2_q <= '0;
      first_q <= '0;
      cnt1_q <= '0;
      first_v_q <= 1'b0;
    end else begin
      first_v_q <= 1'b0;
      if (take_in) begin
        int1_q <= int1_q + fe_scaled;
        int2_q <= int2_q + int1_q;
        cnt1_q <= cnt1_wrap ? 8'h00 : cnt1_q + 8'h01;
        if (cnt1_wrap) begin
          comb1_q <= int2_q;
          comb2_q <= c1;
          first_q <= c2;
          first_v_q <= 1'b1;
        end
      end
    end
  end

  assign first_out_valid = first_v_q;
  assign first_out_data = first_q;

  // ----------------------------------------------------------------
  // Second decimator scaling and rate counters
  // ----------------------------------------------------------------
  wire [4:0] s2_eff = (cfg_q.second_decim_scale > rxc_pkg::S2_MAX) ?
    rxc_pkg::S2_MAX : cfg_q.second_decim_scale;
  logic signed [rxc_pkg::FE_W-1:0] second_in_q;
  logic second_v_q;
  logic [7:0] cnt2_q;
  logic [7:0] cnt3_q;
  logic fir_start_q;
  wire cnt2_wrap = (cnt2_q >= cfg_q.second_decim_ratio_minus_one);
  wire cnt3_wrap = (cnt3_q >= cfg_q.fir_decim_ratio_minus_one);

  always_ff @(posedge clk) begin
    if (rst) begin
      second_in_q <= '0;
      second_v_q <= 1'b0;
      cnt2_q <= '0;
      cnt3_q <= '0;
      fir_start_q <= 1'b0;
    end else begin
      second_v_q <= first_v_q;
      fir_start_q <= 1'b0;
      if (first_v_q) begin
        second_in_q <= first_q >>> s2_eff;
        cnt2_q <= cnt2_wrap ? 8'h00 : cnt2_q + 8'h01;
        if (cnt2_wrap) begin
          cnt3_q <= cnt3_wrap ? 8'h00 : cnt3_q + 8'h01;
          fir_start_q <= cnt3_wrap;
        end
      end
    end
  end

  assign second_in_valid = second_v_q;
  assign second_in_data = second_in_q;

  // ----------------------------------------------------------------
  // Coefficient address walk
  // ----------------------------------------------------------------
  rxc_pkg::rxc_tap_e tap_st_q;
  logic [7:0] tap_idx_q;
  wire tap_last = (tap_idx_q >= cfg_q.fir_tap_count_minus_one);

  always_ff @(posedge clk) begin
    if (rst || !running) begin
      tap_st_q <= rxc_pkg::RXC_TAP_IDLE;
      tap_idx_q <= '0;
    end else begin
      case (tap_st_q)
        rxc_pkg::RXC_TAP_IDLE: begin
          tap_idx_q <= '0;
          if (fir_start_q) begin
            tap_st_q <= rxc_pkg::RXC_TAP_WALK;
          end
        end
        rxc_pkg::RXC_TAP_WALK: begin
          tap_idx_q <= tap_idx_q + 8'h01;
          if (tap_last) begin
            tap_st_q <= rxc_pkg::RXC_TAP_LAST;
          end
        end
        rxc_pkg::RXC_TAP_LAST: begin
          tap_st_q <= rxc_pkg::RXC_TAP_IDLE;
        end
        default: tap_st_q <= rxc_pkg::RXC_TAP_IDLE;
      endcase
    end
  end

  assign coef_rd_en = (tap_st_q == rxc_pkg::RXC_TAP_WALK);
  assign coef_addr = cfg_q.fir_coef_base_offset + tap_idx_q;
  assign coef_walk_busy = (tap_st_q != rxc_pkg::RXC_TAP_IDLE);

  // ----------------------------------------------------------------
  // Output scaling and rounding
  // ----------------------------------------------------------------
  localparam int SCL_W = rxc_pkg::FIR_W + 8;
  wire [2:0] sout = cfg_q.output_scale_control[rxc_pkg::SOUT_MSB:rxc_pkg::SOUT_LSB];
  wire [3:0] up_out = rxc_pkg::SOUT_BASE - {1'b0, sout};
  wire signed [SCL_W-1:0] fir_ext = SCL_W'(signed'(fir_result_23b.data));
  wire signed [SCL_W-1:0] fir_up = fir_ext <<< up_out;
  wire signed [SCL_W-1:0] fir_rnd = fir_up + SCL_W'(64);
  wire signed [SCL_W-1:0] pol_full = fir_rnd >>> rxc_pkg::SOUT_BASE;
  wire pol_hi = (pol_full > SCL_W'(32767));
  wire pol_lo = (pol_full < -SCL_W'(32768));
  wire [rxc_pkg::POL_W-1:0] pol16 = pol_hi ? 16'h7fff :
    (pol_lo ? 16'h8000 : pol_full[rxc_pkg::POL_W-1:0]);
  wire [rxc_pkg::OUT_W-1:0] wide_word = rxc_pkg::OUT_W'(signed'(fir_result_23b.data));
  wire [rxc_pkg::OUT_W-1:0] out_sel = (serial_word_length == rxc_pkg::RXC_WL_16) ?
    {16'h0000, pol16} : wide_word;
  logic [rxc_pkg::OUT_W-1:0] out_word_q;
  logic out_push_q;
  logic first_done_q;

  always_ff @(posedge clk) begin
    if (rst || !running) begin
      out_word_q <= '0;
      out_push_q <= 1'b0;
      first_done_q <= 1'b0;
    end else begin
      out_push_q <= fir_result_23b.valid;
      if (fir_result_23b.valid) begin
        first_done_q <= 1'b1;
        out_word_q <= first_done_q ? out_sel : '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO, flushed and silent in soft reset
  // ----------------------------------------------------------------
  logic fifo_out_valid;

  rxc_fifo #(
    .WIDTH(rxc_pkg::OUT_W),
    .DEPTH(rxc_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk(clk),
    .rst(rst),
    .flush(!running),
    .in_valid(out_push_q),
    .in_ready(fifo_in_ready),
    .in_data(out_word_q),
    .out_valid(fifo_out_valid),
    .out_ready(out_ready && running),
    .out_data(scaled_output_word)
  );

  assign out_valid = fifo_out_valid && running;
endmodule : rxc_top
`default_nettype wire

// ### test/rxc_top_assertions.sv
// Concurrent checks on the receiver configuration bank ports.
// Assumes a bind onto rxc_top, one clock and a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module rxc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic cfg_wr_en,
  input wire logic [rxc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [rxc_pkg::DATA_W-1:0] cfg_wdata,
  input wire rxc_pkg::rxc_cfg_s cfg,
  // Mode view
  input wire logic soft_reset_active,
  input wire logic diversity_real_mode,
  input wire logic single_complex_mode,
  input wire logic sync_master,
  // Datapath
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [15:0] osc_phase,
  input wire logic first_out_valid,
  input wire logic [rxc_pkg::FE_W-1:0] first_out_data,
  input wire logic second_in_valid,
  input wire logic [rxc_pkg::FE_W-1:0] second_in_data,
  input wire logic coef_rd_en,
  input wire logic [7:0] coef_addr,
  input wire logic coef_walk_busy,
  input wire logic out_valid
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [4:0] s2_eff;
  assign s2_eff = (cfg.second_decim_scale > rxc_pkg::S2_MAX) ? rxc_pkg::S2_MAX :
                  cfg.second_decim_scale;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_reset_mode: assert property ($fell(rst) |-> cfg.mode == 8'h01 && sync_master == 1'b0)
    else $error("mode not soft reset slave after reset");
  chk_phase_cleared: assert property ($fell(rst) |-> osc_phase == 16'h0)
    else $error("oscillator phase not cleared by reset");
  chk_soft_idle: assert property (soft_reset_active |-> !in_ready && !out_valid)
    else $error("data moves in soft reset");
  chk_soft_bit: assert property (soft_reset_active == cfg.mode[0])
    else $error("soft reset flag differs from mode bit 0");
  chk_tune_write: assert property (cfg_wr_en && cfg_addr == rxc_pkg::ADDR_TUNE |=>
    cfg.osc_tuning_word == 32'($past(cfg_wdata))) else $error("tuning word not written");
  chk_phase_write: assert property (cfg_wr_en && cfg_addr == rxc_pkg::ADDR_PHASE |=>
    cfg.osc_phase_shift == 16'($past(cfg_wdata))) else $error("phase shift not written");
  chk_mode_flags: assert property (cfg_wr_en && cfg_addr == rxc_pkg::ADDR_MODE |=>
    {sync_master, single_complex_mode, diversity_real_mode, soft_reset_active} ==
    $past(cfg_wdata[3:0])) else $error("mode flags differ from mode register");
  chk_first_pulse: assert property (in_valid && in_ready &&
    cfg.first_decim_ratio_minus_one == 8'h0 |=> first_out_valid)
    else $error("no first decimator output at ratio one");
  chk_second_scale: assert property (first_out_valid && !soft_reset_active |=>
    second_in_valid && $signed(second_in_data) == ($signed($past(first_out_data)) >>>
    $past(s2_eff))) else $error("second stage input wrongly scaled");
  chk_coef_window: assert property (coef_rd_en |->
    8'(coef_addr - cfg.fir_coef_base_offset) <= cfg.fir_tap_count_minus_one)
    else $error("coefficient address outside window");
  chk_walk_end: assert property ($fell(coef_rd_en) && !soft_reset_active |->
    coef_walk_busy ##1 !coef_walk_busy) else $error("walk end not flagged");
endmodule : rxc_chk
`default_nettype wire

// ### test/rxc_host_model.sv
// Host processor model driving the internal register port.
// Assumes the caller runs one access at a time.
`timescale 1ns/1ns
`default_nettype none
module rxc_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic cfg_wr_en,
  output logic cfg_rd_en,
  output logic [rxc_pkg::ADDR_W-1:0] cfg_addr,
  output logic [rxc_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic [rxc_pkg::DATA_W-1:0] cfg_rdata
);
  initial begin
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_addr = '0;
    cfg_wdata = '0;
  end
  // ----------------------------------------------------------------
  // Accesses over the parallel port only
  // ----------------------------------------------------------------
  task automatic wr(input logic [9:0] a, input logic [35:0] d);
    @(posedge clk);
    #1;
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr_en = 1'b0;
    cfg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [35:0] d);
    @(posedge clk);
    #1;
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1;
    cfg_rd_en = 1'b0;
    @(posedge clk);
    #1;
    d = cfg_rdata;
  endtask : rd
endmodule : rxc_host
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the receiver configuration bank.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, g); err_total++; end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr_en, cfg_rd_en;
  logic [rxc_pkg::ADDR_W-1:0] cfg_addr;
  logic [rxc_pkg::DATA_W-1:0] cfg_wdata, cfg_rdata, rdv, wv;
  logic soft_reset_active, diversity_real_mode, single_complex_mode, sync_master;
  logic in_valid = 1'b0, out_ready = 1'b1, in_ready, first_out_valid, out_valid;
  logic [15:0] in_mantissa = 16'h0;
  logic [2:0] input_exponent = 3'h0;
  rxc_pkg::rxc_fir_s fir_q = '0;
  rxc_pkg::rxc_wl_e wl_q = rxc_pkg::RXC_WL_16;
  logic [rxc_pkg::OUT_W-1:0] scaled_output_word, ev;
  logic [31:0] exp_q [$];
  logic [35:0] regm [3:13];
  logic [35:0] msk [3:13] = '{36'hffffffff, 36'hffff, 36'hf7, 36'hf, 36'h1f, 36'h1f,
    36'h7, 36'h1f, 36'hff, 36'hff, 36'h0};
  int err_total = 0, checked = 0, cyc = 0, takes = 0, firsts = 0, sout = 4;
  bit first_word = 1'b1;
  always #5 clk = ~clk;
  rxc_host u_host (.clk(clk), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  rxc_top u_dut (.clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg(),
    .soft_reset_active(soft_reset_active), .diversity_real_mode(diversity_real_mode),
    .single_complex_mode(single_complex_mode), .sync_master(sync_master),
    .in_valid(in_valid), .in_ready(in_ready), .in_mantissa(in_mantissa),
    .input_exponent(input_exponent), .osc_phase(), .first_out_valid(first_out_valid),
    .first_out_data(), .second_in_valid(), .second_in_data(), .coef_rd_en(),
    .coef_addr(), .coef_walk_busy(), .fir_result_23b(fir_q), .serial_word_length(wl_q),
    .out_valid(out_valid), .out_ready(out_ready), .scaled_output_word(scaled_output_word));
  // ----------------------------------------------------------------
  // Closing, monitor and helpers
  // ----------------------------------------------------------------
  task test_done;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (in_valid && in_ready) takes++;
    if (first_out_valid === 1'b1) firsts++;
    if (!rst && out_valid === 1'b1 && out_ready) begin
      ev = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
      `CHK("scaled_output_word", ev, scaled_output_word)
    end
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic fir_push(input int d);
    int v;
    v = ((d <<< (7 - sout)) + 64) >>> 7;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    v = (wl_q == rxc_pkg::RXC_WL_16) ? {16'h0, 16'(v)} : d;
    exp_q.push_back(first_word ? 32'h0 : 32'(v));
    first_word = 1'b0;
    fir_q.valid = 1'b1;
    fir_q.data = 23'(d);
    @(posedge clk);
    #1;
  endtask : fir_push
  task automatic drain;
    for (int t = 0; t < 300 && exp_q.size() > 0; t++) begin
      out_ready = 1'($urandom);
      @(posedge clk);
      #1;
    end
    `CHK("queue_left", 0, exp_q.size())
  endtask : drain
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hbd6235cb));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("soft_reset_active", 1'b1, soft_reset_active)
    `CHK("in_ready", 1'b0, in_ready)
    u_host.rd(rxc_pkg::ADDR_MODE, rdv);
    `CHK("mode", 36'h1, rdv)
    $display("test reset done");
    for (int i = 3; i <= 13; i++) begin
      regm[i] = 36'({$urandom, $urandom}) & msk[i];
      u_host.wr(10'h300 + 10'(i), regm[i]);
    end
    u_host.wr(10'h3ff, 36'hff);
    for (int i = 3; i <= 13; i++) begin
      u_host.rd(10'h300 + 10'(i), rdv);
      `CHK("reg_readback", regm[i], rdv)
    end
    u_host.rd(10'h3ff, rdv);
    `CHK("unmapped", 36'h0, rdv)
    $display("test registers done");
    u_host.wr(rxc_pkg::ADDR_R1, 36'h0);
    u_host.wr(rxc_pkg::ADDR_R2, 36'h0);
    u_host.wr(rxc_pkg::ADDR_RF, 36'h0);
    u_host.wr(rxc_pkg::ADDR_TAPS, 36'h3);
    u_host.wr(rxc_pkg::ADDR_OUT_CTL, 36'h4);
    for (int b = 1; b <= 3; b++) begin
      u_host.wr(rxc_pkg::ADDR_MODE, 36'(1 << b));
      `CHK("mode_flags", 4'(1 << b), {sync_master, single_complex_mode, diversity_real_mode, soft_reset_active})
    end
    u_host.wr(rxc_pkg::ADDR_MODE, 36'h0);
    $display("test modes done");
    takes = 0;
    firsts = 0;
    in_valid = 1'b1;
    repeat (20) begin
      in_mantissa = 16'($urandom);
      input_exponent = 3'($urandom);
      @(posedge clk);
      #1;
    end
    in_valid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("takes", 20, takes)
    `CHK("first_pulses", takes, firsts)
    $display("test input done");
    for (int k = 0; k < 12; k++) begin
      wl_q = rxc_pkg::rxc_wl_e'(k % 3);
      sout = $urandom_range(7);
      u_host.wr(rxc_pkg::ADDR_OUT_CTL, 36'(sout));
      fir_push(int'($urandom) >>> (9 + $urandom_range(13)));
      fir_q.valid = 1'b0;
      drain();
    end
    $display("test scaling done");
    @(posedge clk);
    #1;
    wl_q = rxc_pkg::RXC_WL_32;
    out_ready = 1'b0;
    for (int k = 0; k < rxc_pkg::FIFO_DEPTH; k++) fir_push(int'($urandom) >>> 9);
    fir_q.valid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("full_in_ready", 1'b0, in_ready)
    `CHK("full_out_valid", 1'b1, out_valid)
    drain();
    $display("test buffer done");
    u_host.wr(rxc_pkg::ADDR_MODE, 36'h1);
    `CHK("soft_again", 1'b1, soft_reset_active)
    `CHK("in_ready_soft", 1'b0, in_ready)
    $display("test reinit done");
    test_done();
  end
endmodule : tb
bind rxc_top rxc_chk u_chk (.clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg(cfg),
  .soft_reset_active(soft_reset_active), .diversity_real_mode(diversity_real_mode),
  .single_complex_mode(single_complex_mode), .sync_master(sync_master),
  .in_valid(in_valid), .in_ready(in_ready), .osc_phase(osc_phase),
  .first_out_valid(first_out_valid), .first_out_data(first_out_data),
  .second_in_valid(second_in_valid), .second_in_data(second_in_data),
  .coef_rd_en(coef_rd_en), .coef_addr(coef_addr), .coef_walk_busy(coef_walk_busy),
  .out_valid(out_valid));
`default_nettype wire
